// ### src/sfm_consts.vh
// register map, field positions and timing counts of the fault monitor
// assumes inclusion by the single design file only
`ifndef SFM_CONSTS_VH
`define SFM_CONSTS_VH

// ************************************************************
// register byte addresses
// ************************************************************
`define SFM_ADDR_STATUS 12'h000
`define SFM_ADDR_MASK 12'h004
`define SFM_ADDR_ALARM 12'h008
`define SFM_ADDR_SUB 12'h00C
`define SFM_ADDR_RAW 12'h010

// ************************************************************
// status bit positions
// ************************************************************
`define SFM_B_DAC 0
`define SFM_B_SKY 1
`define SFM_B_CFG 2
`define SFM_B_STORE 3
`define SFM_B_LINK 4
`define SFM_B_REFT 5
`define SFM_B_POLL 6
`define SFM_B_RSUM 7
`define SFM_B_PLL 8
`define SFM_B_FEED 9
`define SFM_B_MOD 10
`define SFM_B_CHAS 11
`define SFM_B_MAIN 12
`define SFM_B_BACK 13
`define SFM_NFAULT 14

// mask register bits
`define SFM_M_FEED 0
`define SFM_M_SKY 1
`define SFM_M_MAIN 2
`define SFM_M_BACK 3
`define SFM_MASK_RST 4'h0

// receiver sub-fault bits
`define SFM_S_SHORT 0
`define SFM_S_OPEN 1
`define SFM_S_OTHER 2

// ************************************************************
// timing
// ************************************************************
`define SFM_UNSYNC_FOM 4'h9
`define SFM_CLK_HZ 10000000
`define SFM_SKY_SECONDS 3600
`define SFM_POLL_MS 10000
// one hour and ten seconds of REF_CLK_I at 10 MHz, as 64-bit counts
`define SFM_SKY_CYCLES 64'h0000_0008_61C4_6800
`define SFM_POLL_CYCLES 64'h0000_0000_05F5_E100

`endif

// ### src/sfm_fault_monitor.v
// system fault monitor: fault flags, masks, alarm output, apb readout
// assumes fault inputs and apb are synchronous to REF_CLK_I
//
// Function
// - alarm on when any unmasked fault active
// - per-fault status readable by host
// - only feed, sky and the two supply faults maskable
// - masked fault excluded, still reported
// - dual supply faults masked independently
// - sky fault after hour unsynced
// - dac fault at limit while locked
// - dac limit fault does not halt operation
// - fatal logic configuration fault
// - parameter store verify fault
// - receiver communication fault
// - bad time input fault
// - poll loss raises host query fault
// - receiver summary on short, open or other receiver fault
// - fatal pll unlock fault
// - feed fault on over or undercurrent
// - unknown plug-in module fault
// - fatal chassis configuration fault
// - supply faults only with dual supplies
// - short and open separate sub-faults
`timescale 1ns/100ps
`include "sfm_consts.vh"

module sfm_fault_monitor #(
    parameter [63:0] SKY_CYCLES = `SFM_SKY_CYCLES,
    parameter [63:0] POLL_CYCLES = `SFM_POLL_CYCLES
) (
    input wire REF_CLK_I,
    input wire RST_B_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output reg [31:0] PRDATA_O,
    output reg PREADY_O,
    output reg PSLVERR_O,
    input wire DAC_AT_LIMIT_I,
    input wire SKY_LOCKED_I,
    input wire SIGNAL_ACQUIRED_I,
    input wire [3:0] TIME_FOM_I,
    input wire LOGIC_CONFIG_FAIL_I,
    input wire STORE_VERIFY_FAIL_I,
    input wire RECEIVER_NO_LINK_I,
    input wire BAD_TIME_INPUT_I,
    input wire HOST_POLL_I,
    input wire RECEIVER_OTHER_FAULT_I,
    input wire PLL_UNLOCK_I,
    input wire FEED_OVERCURRENT_I,
    input wire FEED_UNDERCURRENT_I,
    input wire UNKNOWN_MODULE_I,
    input wire CHASSIS_MISCONFIG_I,
    input wire DUAL_SUPPLY_PRESENT_I,
    input wire MAIN_SUPPLY_DEAD_I,
    input wire BACKUP_SUPPLY_DEAD_I,
    output reg ALARM_LED_O,
    output reg [13:0] FAULT_STATUS_O
);

// ************************************************************
// timers
// ************************************************************
// 64-bit counters: an hour at 10 MHz does not fit in 32 bits
localparam [63:0] SKY_LAST = SKY_CYCLES - 64'h0000_0000_0000_0001;
localparam [63:0] POLL_LAST = POLL_CYCLES - 64'h0000_0000_0000_0001;
reg [63:0] sky_cnt;
reg [63:0] poll_cnt;
reg sky_fault;
reg poll_fault;
wire sky_unsync = !SIGNAL_ACQUIRED_I && (TIME_FOM_I == `SFM_UNSYNC_FOM);
wire sky_done = (sky_cnt >= SKY_LAST);
wire poll_done = (poll_cnt >= POLL_LAST);

// any break in the unsynced condition restarts the hour
always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        sky_cnt <= 64'h0000_0000_0000_0000;
    end else if (!sky_unsync) begin
        sky_cnt <= 64'h0000_0000_0000_0000;
    end else if (!sky_done) begin
        sky_cnt <= sky_cnt + 64'h0000_0000_0000_0001;
    end
end

// count parks at the end, so the flag stays up with the condition
always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        sky_fault <= 1'b0;
    end else if (!sky_unsync) begin
        sky_fault <= 1'b0;
    end else if (sky_done) begin
        sky_fault <= 1'b1;
    end
end

// ************************************************************
// host poll watchdog
// ************************************************************
// host must pulse HOST_POLL_I at least once per poll window
always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        poll_cnt <= 64'h0000_0000_0000_0000;
    end else if (HOST_POLL_I) begin
        poll_cnt <= 64'h0000_0000_0000_0000;
    end else if (!poll_done) begin
        poll_cnt <= poll_cnt + 64'h0000_0000_0000_0001;
    end
end

always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        poll_fault <= 1'b0;
    end else if (HOST_POLL_I) begin
        poll_fault <= 1'b0;
    end else if (poll_done) begin
        poll_fault <= 1'b1;
    end
end

// ************************************************************
// fault conditions
// ************************************************************
reg [3:0] mask;
reg [13:0] next_status;
reg [2:0] next_sub;
reg [13:0] alarm_en;

// one named condition per fault keeps the status map easy to audit
wire cond_dac;
wire cond_sky;
wire cond_cfg;
wire cond_store;
wire cond_link;
wire cond_reft;
wire cond_poll;
wire cond_rsum;
wire cond_pll;
wire cond_feed;
wire cond_mod;
wire cond_chas;
wire cond_main;
wire cond_back;
wire cond_short;
wire cond_open;
wire cond_other;

// advisory only; the limit flag holds nothing else back
assign cond_dac = DAC_AT_LIMIT_I && SKY_LOCKED_I;
assign cond_sky = sky_fault;
assign cond_cfg = LOGIC_CONFIG_FAIL_I;
assign cond_store = STORE_VERIFY_FAIL_I;
assign cond_link = RECEIVER_NO_LINK_I;
assign cond_reft = BAD_TIME_INPUT_I;
assign cond_poll = poll_fault;
assign cond_short = FEED_OVERCURRENT_I;
assign cond_open = FEED_UNDERCURRENT_I;
assign cond_other = RECEIVER_OTHER_FAULT_I;
assign cond_rsum = cond_short || cond_open || cond_other;
assign cond_pll = PLL_UNLOCK_I;
assign cond_feed = cond_short || cond_open;
assign cond_mod = UNKNOWN_MODULE_I;
assign cond_chas = CHASSIS_MISCONFIG_I;
// a single-supply chassis never reports a dead supply
assign cond_main = DUAL_SUPPLY_PRESENT_I
    && MAIN_SUPPLY_DEAD_I;
assign cond_back = DUAL_SUPPLY_PRESENT_I
    && BACKUP_SUPPLY_DEAD_I;

always @* begin
    next_sub = 3'h0;
    next_sub[`SFM_S_SHORT] = cond_short;
    next_sub[`SFM_S_OPEN] = cond_open;
    next_sub[`SFM_S_OTHER] = cond_other;
end

always @* begin
    next_status = 14'h0000;
    next_status[`SFM_B_DAC] = cond_dac;
    next_status[`SFM_B_SKY] = cond_sky;
    next_status[`SFM_B_CFG] = cond_cfg;
    next_status[`SFM_B_STORE] = cond_store;
    next_status[`SFM_B_LINK] = cond_link;
    next_status[`SFM_B_REFT] = cond_reft;
    next_status[`SFM_B_POLL] = cond_poll;
    next_status[`SFM_B_RSUM] = cond_rsum;
    next_status[`SFM_B_PLL] = cond_pll;
    next_status[`SFM_B_FEED] = cond_feed;
    next_status[`SFM_B_MOD] = cond_mod;
    next_status[`SFM_B_CHAS] = cond_chas;
    next_status[`SFM_B_MAIN] = cond_main;
    next_status[`SFM_B_BACK] = cond_back;
end

// feed, sky and the two supply faults are the only maskable faults
always @* begin
    alarm_en = 14'h3FFF;
    alarm_en[`SFM_B_FEED] = !mask[`SFM_M_FEED];
    alarm_en[`SFM_B_SKY] = !mask[`SFM_M_SKY];
    alarm_en[`SFM_B_MAIN] = !mask[`SFM_M_MAIN];
    alarm_en[`SFM_B_BACK] = !mask[`SFM_M_BACK];
end

// ************************************************************
// alarm gating
// ************************************************************
// per-fault gating: a bit either feeds the alarm or is parked
wire [13:0] next_alarm_term;
wire [13:0] next_parked;
genvar g;
generate
    for (g = 0; g < `SFM_NFAULT; g = g + 1) begin : g_gate
        assign next_alarm_term[g] = next_status[g] && alarm_en[g];
        assign next_parked[g] = next_status[g] && !alarm_en[g];
    end
endgenerate
wire next_alarm = |next_alarm_term;

// ************************************************************
// status flags and alarm
// ************************************************************
reg [2:0] sub;
reg [13:0] raw;

// status lags the inputs by one cycle; levels only, no latching
always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        FAULT_STATUS_O <= 14'h0000;
    end else begin
        FAULT_STATUS_O <= next_status;
    end
end

// alarm uses the same next values, so it never leads the status
always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        ALARM_LED_O <= 1'b0;
    end else begin
        ALARM_LED_O <= next_alarm;
    end
end

always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        sub <= 3'h0;
    end else begin
        sub <= next_sub;
    end
end

// parked faults stay visible to the host while masked
always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        raw <= 14'h0000;
    end else begin
        raw <= next_parked;
    end
end

// ************************************************************
// apb slave
// ************************************************************
wire setup = PSEL_I && !PENABLE_I;
wire access = PSEL_I && PENABLE_I;
wire sel_status = (PADDR_I == `SFM_ADDR_STATUS);
wire sel_mask = (PADDR_I == `SFM_ADDR_MASK);
wire sel_alarm = (PADDR_I == `SFM_ADDR_ALARM);
wire sel_sub = (PADDR_I == `SFM_ADDR_SUB);
wire sel_raw = (PADDR_I == `SFM_ADDR_RAW);
wire hit = sel_status || sel_mask || sel_alarm || sel_sub || sel_raw;
// the write lands only at the edge that completes the access phase
wire mask_wr = access && PREADY_O && PWRITE_I && sel_mask;
// answers are decided in setup and shown for the one access cycle
wire next_ready = setup;
wire next_err = setup && !hit;
wire rd_setup = setup && !PWRITE_I;
reg [31:0] next_rdata;

// ************************************************************
// register readback
// ************************************************************
// reserved bits of every word read as zero
wire [31:0] status_word = {18'h0_0000, FAULT_STATUS_O};
wire [31:0] mask_word = {28'h000_0000, mask};
wire [31:0] alarm_word = {31'h0000_0000, ALARM_LED_O};
wire [31:0] sub_word = {29'h0000_0000, sub};
wire [31:0] raw_word = {18'h0_0000, raw};

always @* begin
    next_rdata = 32'h0000_0000;
    case (PADDR_I)
        `SFM_ADDR_STATUS: next_rdata = status_word;
        `SFM_ADDR_MASK: next_rdata = mask_word;
        `SFM_ADDR_ALARM: next_rdata = alarm_word;
        `SFM_ADDR_SUB: next_rdata = sub_word;
        `SFM_ADDR_RAW: next_rdata = raw_word;
        default: next_rdata = 32'h0000_0000;
    endcase
end

always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        mask <= `SFM_MASK_RST;
    end else if (mask_wr) begin
        mask <= PWDATA_I[3:0];
    end
end

// no wait state: ready rises in the first access cycle, one cycle after setup
always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        PREADY_O <= 1'b0;
    end else begin
        PREADY_O <= next_ready;
    end
end

// error pulses together with ready on an unmapped address
always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        PSLVERR_O <= 1'b0;
    end else begin
        PSLVERR_O <= next_err;
    end
end

// data only during a read access, zero otherwise
always @(posedge REF_CLK_I) begin
    if (!RST_B_I) begin
        PRDATA_O <= 32'h0000_0000;
    end else begin
        PRDATA_O <= rd_setup ? next_rdata : 32'h0000_0000;
    end
end

endmodule

// ### verification/sfm_host_poller.sv
// host side model: polls the monitor while enabled
// assumes the monitor clock and reset
`timescale 1ns/100ps
module sfm_host_poller (
    input wire clk_i,
    input wire rst_b_i,
    input wire en_i,
    output reg poll_o = 1'b0
);
    reg [1:0] cnt = 2'b00;
    // one pulse every 4 cycles, well inside the poll timeout
    always @(posedge clk_i) begin
        cnt <= (rst_b_i && en_i) ? cnt + 2'd1 : 2'd0;
        poll_o <= rst_b_i && en_i && (&cnt);
    end
endmodule

// ### verification/sfm_fault_monitor_chk.sv
// checker: status, alarm and bus timing at the monitor ports
// assumes binding onto sfm_fault_monitor
`timescale 1ns/100ps
module sfm_chk (
    input wire REF_CLK_I, RST_B_I, PSEL_I, PENABLE_I, PREADY_O,
    input wire [13:0] FAULT_STATUS_O,
    input wire ALARM_LED_O, DAC_AT_LIMIT_I, SKY_LOCKED_I, HOST_POLL_I,
    input wire LOGIC_CONFIG_FAIL_I, STORE_VERIFY_FAIL_I, RECEIVER_NO_LINK_I,
    input wire BAD_TIME_INPUT_I, RECEIVER_OTHER_FAULT_I, PLL_UNLOCK_I,
    input wire FEED_OVERCURRENT_I, FEED_UNDERCURRENT_I, UNKNOWN_MODULE_I,
    input wire CHASSIS_MISCONFIG_I, DUAL_SUPPLY_PRESENT_I,
    input wire MAIN_SUPPLY_DEAD_I, BACKUP_SUPPLY_DEAD_I
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_B_I);
    a_unmask_alarm: assert property (
        (|(FAULT_STATUS_O & 14'h0dfd)) |-> ALARM_LED_O) else $error("alarm off");
    a_quiet_alarm: assert property (
        FAULT_STATUS_O == 14'h0 |-> !ALARM_LED_O) else $error("alarm on");
    a_level_copy: assert property (1'b1 |=> FAULT_STATUS_O[5:2] == $past(
        {BAD_TIME_INPUT_I, RECEIVER_NO_LINK_I, STORE_VERIFY_FAIL_I,
        LOGIC_CONFIG_FAIL_I})) else $error("flag copy");
    a_dac_locked: assert property (1'b1 |=> FAULT_STATUS_O[0] ==
        $past(DAC_AT_LIMIT_I && SKY_LOCKED_I)) else $error("dac flag");
    a_feed_either: assert property (1'b1 |=> FAULT_STATUS_O[9] ==
        $past(FEED_OVERCURRENT_I | FEED_UNDERCURRENT_I)) else $error("feed");
    a_rcv_summary: assert property (1'b1 |=> FAULT_STATUS_O[7] ==
        $past(FEED_OVERCURRENT_I | FEED_UNDERCURRENT_I |
        RECEIVER_OTHER_FAULT_I)) else $error("receiver summary");
    a_fatal_copy: assert property (1'b1 |=> {FAULT_STATUS_O[11:10],
        FAULT_STATUS_O[8]} == $past({CHASSIS_MISCONFIG_I, UNKNOWN_MODULE_I,
        PLL_UNLOCK_I})) else $error("fatal flags");
    a_supply_gate: assert property (1'b1 |=> FAULT_STATUS_O[13:12] ==
        $past({BACKUP_SUPPLY_DEAD_I, MAIN_SUPPLY_DEAD_I} &
        {2{DUAL_SUPPLY_PRESENT_I}})) else $error("supply flags");
    a_poll_clear: assert property (
        HOST_POLL_I |-> ##[1:2] !FAULT_STATUS_O[6]) else $error("poll flag");
    a_apb_wait: assert property (PSEL_I && !PENABLE_I |->
        ##1 PREADY_O ##1 !PREADY_O) else $error("ready timing");
endmodule
bind sfm_fault_monitor sfm_chk u_chk (.*);

// ### verification/sfm_fault_monitor_test.sv
// testbench: random fault levels and masks against a behavioural model
// assumes apb answers with no wait states
`timescale 1ns/100ps
module sfm_fault_monitor_test;
    logic clk = 0, rst_b = 0, psel = 0, pen = 0, chassis_config_fault = 0, en = 1;
    logic [11:0] pa = 0;
    logic [31:0] pwd = 0, q, prd;
    logic [15:0] f = 16'h0004;
    logic [3:0] fom = 0, m;
    logic [13:0] e, st;
    logic pready, perr, alarm, poll, err;
    integer fail_count = 0, n_tests = 0, cyc = 0, i;
    sfm_fault_monitor #(.SKY_CYCLES(20), .POLL_CYCLES(10)) u_dut (
        .REF_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(chassis_config_fault), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
        .PREADY_O(pready), .PSLVERR_O(perr), .DAC_AT_LIMIT_I(f[0]),
        .SKY_LOCKED_I(f[1]), .SIGNAL_ACQUIRED_I(f[2]), .TIME_FOM_I(fom),
        .LOGIC_CONFIG_FAIL_I(f[3]), .STORE_VERIFY_FAIL_I(f[4]),
        .RECEIVER_NO_LINK_I(f[5]), .BAD_TIME_INPUT_I(f[6]),
        .HOST_POLL_I(poll), .RECEIVER_OTHER_FAULT_I(f[7]),
        .PLL_UNLOCK_I(f[8]), .FEED_OVERCURRENT_I(f[9]),
        .FEED_UNDERCURRENT_I(f[10]), .UNKNOWN_MODULE_I(f[11]),
        .CHASSIS_MISCONFIG_I(f[12]), .DUAL_SUPPLY_PRESENT_I(f[13]),
        .MAIN_SUPPLY_DEAD_I(f[14]), .BACKUP_SUPPLY_DEAD_I(f[15]),
        .ALARM_LED_O(alarm), .FAULT_STATUS_O(st));
    sfm_host_poller u_host (.clk_i(clk), .rst_b_i(rst_b), .en_i(en),
        .poll_o(poll));
    initial forever #50 clk = ~clk;
    // ************************************************************
    // model and bus tasks
    // ************************************************************
    function automatic logic [13:0] model(input logic [15:0] v);
        model = {v[15] & v[13], v[14] & v[13], v[12], v[11], v[9] | v[10],
            v[8], v[7] | v[9] | v[10], 1'b0, v[6:3], 1'b0, v[0] & v[1]};
    endfunction
    function automatic logic [13:0] mv(input logic [3:0] k);
        mv = {k[3], k[2], 2'b00, k[0], 7'h00, k[1], 1'b0};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        chassis_config_fault <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prd;
        err = perr;
        psel <= 0;
        pen <= 0;
    endtask
    task complete_run;
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // cycle ceiling well above the roughly 670 cycles of the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            complete_run;
        end
    end
    initial begin
        void'($urandom(32'h7c33));
        repeat (4) @(posedge clk);
        rst_b <= 1;
        apb(0, 12'h004, 0);
        chk(q, 0);
        for (i = 0; i < 40; i++) begin
            m = 4'($urandom);
            apb(1, 12'h004, {28'($urandom), m});
            f <= 16'($urandom);
            fom <= 4'($urandom % 9);
            apb(0, 12'h000, 0);
            e = model(f);
            chk(q, {18'h0, e});
            chk(alarm, |(e & ~mv(m)));
            apb(0, 12'h004, 0);
            chk(q, {28'h0, m});
            apb(0, 12'h00c, 0);
            chk(q, {29'h0, f[7], f[10], f[9]});
            apb(0, 12'h010, 0);
            chk(q, {18'h0, e & mv(m)});
        end
        $display("random faults done");
        apb(0, 12'h014, 0);
        chk(q, 0);
        chk({31'h0, err}, 1);
        apb(1, 12'h004, 0);
        f <= 0;
        fom <= 9;
        repeat (16) @(posedge clk);
        chk(st[1], 0);
        repeat (8) @(posedge clk);
        chk({st[1], alarm}, 2'b11);
        apb(1, 12'h004, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk({st[1], alarm}, 2'b10);
        f <= 16'h0004;
        repeat (3) @(posedge clk);
        chk(st[1], 0);
        $display("sky fault done");
        en <= 0;
        repeat (14) @(posedge clk);
        chk({st[6], alarm}, 2'b11);
        en <= 1;
        repeat (8) @(posedge clk);
        chk(st[6], 0);
        $display("poll fault done");
        complete_run;
    end
endmodule
